// [rtl/sdc_mem.sv]
// device end: samples the command pins, keeps per-bank state, data path with byte masks
// assumes controller shares clk_i; data array is a small model-sized memory
`timescale 1ns/1ps
module sdc_mem
    import sdc_pkg::*;
#(
    parameter int DEPTH_W = 6,
    parameter int CAS_LAT = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    sdc_if.mem pins,
    output logic [NBANK-1:0] bank_open_o,
    output logic suspend_o,
    output logic power_down_o,
    output logic self_refresh_o,
    output logic [ADDR_W+BANK_W-1:0] mode_word_o,
    output logic [7:0] refresh_count_o
);
    typedef struct packed {
        logic cke_prev;
        logic [NBANK-1:0] open;
        logic [NBANK-1:0][ADDR_W-1:0] row;
        logic suspend;
        logic pdown;
        logic sref;
        logic [ADDR_W+BANK_W-1:0] mode;
        logic [7:0] refs;
        logic bursting;
        logic writing;
        logic [BURST_W-1:0] left;
        logic [BANK_W-1:0] bk;
        logic [COL_W-1:0] col;
        logic ap;
        logic [CAS_LAT-1:0] rd_pipe;
        logic [CAS_LAT-1:0][DEPTH_W-1:0] rd_addr;
        logic [MASK_LAT-1:0][MASK_W-1:0] mask_pipe;
        logic [DATA_W-1:0] dq_out;
        logic [MASK_W-1:0] dq_oe_n;
    } sdc_mem_t;
    sdc_mem_t st_reg, st_next;
    logic [DATA_W-1:0] mem [2**DEPTH_W];
    logic [3:0] code;
    sdc_op_t op;
    logic [BANK_W-1:0] ba;
    logic [BURST_W-1:0] blen;
    logic [DEPTH_W-1:0] waddr;
    logic wr_en;

    assign code = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
    assign ba = {pins.bank_select_hi, pins.bank_select_lo};
    // burst length code in low mode bits: 0..3 -> 1,2,4,8, 7 -> full page
    assign blen = (st_reg.mode[2:0] == 3'h7) ? BURST_FULL :
        BURST_W'(9'h1 << st_reg.mode[1:0]);
    assign waddr = DEPTH_W'({st_reg.bk, st_reg.col});

    always_comb begin
        unique case (code)
            CMD_ACT: op = SDC_OP_ACT;
            CMD_PRE: op = SDC_OP_PRE;
            CMD_RD: op = SDC_OP_RD;
            CMD_WR: op = SDC_OP_WR;
            CMD_MRS: op = SDC_OP_MRS;
            CMD_REF: op = SDC_OP_REF;
            CMD_BST: op = SDC_OP_BST;
            default: op = SDC_OP_NOP; // nop and deselect
        endcase
    end

    always_comb begin
        st_next = st_reg;
        wr_en = 1'b0;
        st_next.cke_prev = pins.clk_en;
        if (!st_reg.cke_prev) begin
            // frozen: outputs and burst address hold
            if (pins.clk_en) begin
                st_next.suspend = 1'b0;
                st_next.pdown = 1'b0;
                st_next.sref = 1'b0;
            end
        end else begin
            st_next.mask_pipe = {st_reg.mask_pipe[MASK_LAT-2:0], pins.byte_lane_mask};
            st_next.rd_pipe = {st_reg.rd_pipe[CAS_LAT-2:0], 1'b0};
            st_next.rd_addr = {st_reg.rd_addr[CAS_LAT-2:0], waddr};
            if (st_reg.bursting) begin
                st_next.col = st_reg.col + COL_W'(1);
                if (st_reg.writing) begin
                    wr_en = 1'b1;
                end else begin
                    st_next.rd_pipe[0] = 1'b1;
                end
                if (st_reg.left == BURST_W'(1) && blen != BURST_FULL) begin
                    st_next.bursting = 1'b0;
                    if (st_reg.ap) begin
                        st_next.open[st_reg.bk] = 1'b0;
                    end
                end
                st_next.left = st_reg.left - BURST_W'(1);
            end
            unique case (op)
                SDC_OP_ACT: begin
                    st_next.open[ba] = 1'b1;
                    st_next.row[ba] = pins.addr_bus;
                end
                SDC_OP_PRE: begin
                    st_next.bursting = 1'b0;
                    if (pins.addr_bus[AP_BIT]) begin
                        st_next.open = '0;
                    end else begin
                        st_next.open[ba] = 1'b0;
                    end
                end
                SDC_OP_RD, SDC_OP_WR: begin
                    st_next.bk = ba;
                    st_next.col = pins.addr_bus[COL_W-1:0];
                    st_next.ap = pins.addr_bus[AP_BIT] && blen != BURST_FULL;
                    st_next.writing = (op == SDC_OP_WR);
                    st_next.bursting = 1'b1;
                    st_next.left = blen;
                    if (op == SDC_OP_WR) begin
                        // first write beat is taken one cycle after the command, into this bank
                        st_next.bk = ba;
                    end
                end
                SDC_OP_MRS: begin
                    if (st_reg.open == '0) begin
                        st_next.mode = {ba, pins.addr_bus};
                    end
                end
                SDC_OP_REF: begin
                    if (st_reg.open == '0) begin
                        if (pins.clk_en) begin
                            st_next.refs = st_reg.refs + 8'h01;
                        end else begin
                            st_next.sref = 1'b1;
                        end
                    end
                end
                SDC_OP_BST: st_next.bursting = 1'b0;
                default: ;
            endcase
            if (!pins.clk_en && op != SDC_OP_REF) begin
                // an open bank or a burst in flight turns power down into suspend
                if (st_reg.open != '0 || st_reg.bursting) begin
                    st_next.suspend = 1'b1;
                end else begin
                    st_next.pdown = 1'b1;
                end
            end
            st_next.dq_oe_n = {MASK_W{1'b1}};
            if (st_reg.rd_pipe[CAS_LAT-1]) begin
                st_next.dq_out = mem[st_reg.rd_addr[CAS_LAT-1]];
                st_next.dq_oe_n = st_reg.mask_pipe[MASK_LAT-2];
            end
        end
    end

    // write beat: the current edge's data with the mask sampled alongside it
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            for (int i = 0; i < MASK_W; i++) begin
                if (!pins.byte_lane_mask[i]) begin
                    mem[waddr][8*i +: 8] <= pins.data_io[8*i +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.dq_oe_n <= {MASK_W{1'b1}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins.mem_dq_out = st_reg.dq_out;
    assign pins.mem_dq_oe_n = st_reg.dq_oe_n;
    assign bank_open_o = st_reg.open;
    assign suspend_o = st_reg.suspend;
    assign power_down_o = st_reg.pdown;
    assign self_refresh_o = st_reg.sref;
    assign mode_word_o = st_reg.mode;
    assign refresh_count_o = st_reg.refs;
endmodule : sdc_mem

// [pkg/sdc_pkg.sv]
// package: command codes, pin widths and mode constants of the sdram command decoder
// assumes a single clock shared by controller end and device end
package sdc_pkg;
    localparam int ADDR_W = 12;
    localparam int COL_W = 8;
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int DATA_W = 32;
    localparam int MASK_W = 4;
    localparam int AP_BIT = 10;
    localparam int MASK_LAT = 2;
    localparam int BURST_W = 9;
    localparam logic [BURST_W-1:0] BURST_FULL = 9'h100;
    // {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_RD = 4'h5;
    localparam logic [3:0] CMD_WR = 4'h4;
    localparam logic [3:0] CMD_MRS = 4'h0;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_DESEL = 4'hF;
    typedef enum logic [2:0] {
        SDC_OP_NOP,
        SDC_OP_ACT,
        SDC_OP_PRE,
        SDC_OP_RD,
        SDC_OP_WR,
        SDC_OP_MRS,
        SDC_OP_REF,
        SDC_OP_BST
    } sdc_op_t;
endpackage : sdc_pkg

// [pkg/sdc_if.sv]
// interface: sdram pins between controller end and device end
// assumes the bench resolves data_io from the two output enables
`timescale 1ns/1ps
interface sdc_if;
    import sdc_pkg::*;
    logic clk_en;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_select_lo;
    logic bank_select_hi;
    logic [ADDR_W-1:0] addr_bus;
    logic [MASK_W-1:0] byte_lane_mask;
    logic [DATA_W-1:0] ctl_dq_out;
    logic ctl_dq_oe_n;
    logic [DATA_W-1:0] mem_dq_out;
    logic [MASK_W-1:0] mem_dq_oe_n;
    logic [DATA_W-1:0] data_io;
    modport ctl (output clk_en, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi,
        addr_bus, byte_lane_mask, ctl_dq_out, ctl_dq_oe_n, input data_io);
    modport mem (input clk_en, cs_n, ras_n, cas_n, we_n, bank_select_lo, bank_select_hi,
        addr_bus, byte_lane_mask, data_io, output mem_dq_out, mem_dq_oe_n);
endinterface : sdc_if

// [rtl/sdc_ctl.sv]
// controller end: turns a one-cycle user request into pin commands
// assumes the user only asks for legal sequences; bank tracking guards activate and access
`timescale 1ns/1ps
module sdc_ctl
    import sdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic req_i,
    input wire sdc_op_t op_i,
    input wire logic [BANK_W-1:0] bank_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [MASK_W-1:0] mask_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic cke_i,
    output logic refused_o,
    output logic [DATA_W-1:0] rdata_o,
    output logic [NBANK-1:0] bank_open_o,
    sdc_if.ctl pins
);
    typedef struct packed {
        logic cke;
        logic [3:0] code;
        logic [BANK_W-1:0] ba;
        logic [ADDR_W-1:0] addr;
        logic [MASK_W-1:0] mask;
        logic [DATA_W-1:0] dq;
        logic dq_oe_n;
        logic refused;
        logic [NBANK-1:0] open;
        logic [DATA_W-1:0] rdata;
        logic wr_go;
        logic [MASK_W-1:0] wmask;
        logic [DATA_W-1:0] wdata;
    } sdc_ctl_t;
    sdc_ctl_t st_reg, st_next;
    logic legal;

    always_comb begin
        st_next = st_reg;
        st_next.cke = cke_i;
        st_next.code = CMD_NOP;
        st_next.mask = mask_i;
        st_next.dq_oe_n = 1'b1;
        st_next.refused = 1'b0;
        st_next.rdata = pins.data_io;
        legal = 1'b1;
        if (req_i) begin
            unique case (op_i)
                SDC_OP_ACT: legal = !st_reg.open[bank_i];
                SDC_OP_RD, SDC_OP_WR: legal = st_reg.open[bank_i];
                SDC_OP_MRS, SDC_OP_REF: legal = (st_reg.open == '0);
                default: legal = 1'b1;
            endcase
            if (!cke_i && st_reg.open != '0) begin
                legal = 1'b0;
            end
            if (legal) begin
                st_next.ba = bank_i;
                st_next.addr = addr_i;
                unique case (op_i)
                    SDC_OP_ACT: st_next.code = CMD_ACT;
                    SDC_OP_PRE: st_next.code = CMD_PRE;
                    SDC_OP_RD: st_next.code = CMD_RD;
                    SDC_OP_WR: st_next.code = CMD_WR;
                    SDC_OP_MRS: st_next.code = CMD_MRS;
                    SDC_OP_REF: st_next.code = CMD_REF;
                    SDC_OP_BST: st_next.code = CMD_BST;
                    default: st_next.code = CMD_NOP;
                endcase
                if (op_i == SDC_OP_ACT) begin
                    st_next.open[bank_i] = 1'b1;
                end
                if (op_i == SDC_OP_PRE) begin
                    if (addr_i[AP_BIT]) begin
                        st_next.open = '0;
                    end else begin
                        st_next.open[bank_i] = 1'b0;
                    end
                end
                if ((op_i == SDC_OP_RD || op_i == SDC_OP_WR) && addr_i[AP_BIT]) begin
                    st_next.open[bank_i] = 1'b0;
                end
            end else begin
                st_next.refused = 1'b1;
            end
        end
        // data and its mask trail the write code by one cycle, where the device takes the beat
        st_next.wr_go = req_i && legal && op_i == SDC_OP_WR;
        st_next.wmask = mask_i;
        st_next.wdata = wdata_i;
        if (st_reg.wr_go) begin
            st_next.dq = st_reg.wdata;
            st_next.mask = st_reg.wmask;
            st_next.dq_oe_n = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.cke <= 1'b1;
            st_reg.code <= CMD_DESEL;
            st_reg.mask <= {MASK_W{1'b1}};
            st_reg.dq_oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins.clk_en = st_reg.cke;
    assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = st_reg.code;
    assign {pins.bank_select_hi, pins.bank_select_lo} = st_reg.ba;
    assign pins.addr_bus = st_reg.addr;
    assign pins.byte_lane_mask = st_reg.mask;
    assign pins.ctl_dq_out = st_reg.dq;
    assign pins.ctl_dq_oe_n = st_reg.dq_oe_n;
    assign refused_o = st_reg.refused;
    assign rdata_o = st_reg.rdata;
    assign bank_open_o = st_reg.open;
endmodule : sdc_ctl

// [sim/sdc_chk_sva.sv]
// checker: pin-level protocol between controller end and device end
// assumes it watches the shared interface signals, one clock, async low reset
`timescale 1ns/1ps
module sdc_chk
    import sdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic bank_select_lo,
    input wire logic bank_select_hi,
    input wire logic [ADDR_W-1:0] addr_bus,
    input wire logic [MASK_W-1:0] byte_lane_mask,
    input wire logic ctl_dq_oe_n,
    input wire logic [MASK_W-1:0] mem_dq_oe_n
);
    logic cke_q;
    logic [NBANK-1:0] open_q;
    logic [3:0] cmd;
    logic [BANK_W-1:0] ba;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    assign ba = {bank_select_hi, bank_select_lo};
    // bank view rebuilt from the wire; auto-close treated as immediate
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cke_q <= 1'b1;
            open_q <= '0;
        end else begin
            cke_q <= clk_en;
            if (cke_q && cmd == CMD_ACT) open_q[ba] <= 1'b1;
            else if (cke_q && cmd == CMD_PRE && addr_bus[AP_BIT]) open_q <= '0;
            else if (cke_q && (cmd == CMD_PRE || ((cmd == CMD_RD || cmd == CMD_WR)
                && addr_bus[AP_BIT]))) open_q[ba] <= 1'b0;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    property p_act_idle;
        cke_q && cmd == CMD_ACT |-> !open_q[ba];
    endproperty
    a_act_idle: assert property (p_act_idle) else $error("activate to open bank");
    property p_access_open;
        cke_q && (cmd == CMD_RD || cmd == CMD_WR) |-> open_q[ba];
    endproperty
    a_access_open: assert property (p_access_open) else $error("access to idle bank");
    property p_mrs_idle;
        cke_q && (cmd == CMD_MRS || cmd == CMD_REF) |-> open_q == '0;
    endproperty
    a_mrs_idle: assert property (p_mrs_idle) else $error("mode or refresh not idle");
    property p_no_clash;
        !ctl_dq_oe_n |-> mem_dq_oe_n == '1;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
    property p_mask_lat;
        (~mem_dq_oe_n & $past(byte_lane_mask, 2)) == '0;
    endproperty
    a_mask_lat: assert property (p_mask_lat) else $error("masked lane driven");
    property p_wr_data;
        cke_q && cmd == CMD_WR |=> !ctl_dq_oe_n;
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write data not driven");
    property p_rd_drive;
        cke_q && clk_en && cmd == CMD_RD && byte_lane_mask == '0 |-> ##[1:6] mem_dq_oe_n == '0;
    endproperty
    a_rd_drive: assert property (p_rd_drive) else $error("read data missing");
    property p_freeze;
        !$past(clk_en) && !$past(clk_en, 2) |-> $stable(mem_dq_oe_n);
    endproperty
    a_freeze: assert property (p_freeze) else $error("outputs moved in suspend");
endmodule : sdc_chk

// [sim/sdram_command_decode_tb.sv]
// testbench: controller end facing device end, user side driven by hand-written tests
// assumes the bench holds mask and cke levels from the last request between requests
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module sdram_command_decode_tb
    import sdc_pkg::*;
();
    logic clk_i, rst_n_i, req, cke, refused_o, suspend, pdown, sref;
    logic flt = 1'b0;
    sdc_op_t op;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic [MASK_W-1:0] mask;
    logic [DATA_W-1:0] wdata, rdata_o;
    logic [NBANK-1:0] ctl_open, mem_open;
    logic [ADDR_W+BANK_W-1:0] mode_word;
    logic [7:0] ref_cnt;
    int failures = 0;
    int checked = 0;
    int refusals = 0;
    sdc_if sdc_if_i();
    sdc_ctl sdc_ctl_i(.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .op_i(op), .bank_i(bank),
        .addr_i(addr), .mask_i(mask), .wdata_i(wdata), .cke_i(cke), .refused_o(refused_o),
        .rdata_o(rdata_o), .bank_open_o(ctl_open), .pins(sdc_if_i));
    sdc_mem sdc_mem_i(.clk_i(clk_i), .rst_n_i(rst_n_i), .pins(sdc_if_i), .bank_open_o(mem_open),
        .suspend_o(suspend), .power_down_o(pdown), .self_refresh_o(sref),
        .mode_word_o(mode_word), .refresh_count_o(ref_cnt));
    sdc_chk sdc_chk_i(.clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en(sdc_if_i.clk_en),
        .cs_n(sdc_if_i.cs_n), .ras_n(sdc_if_i.ras_n), .cas_n(sdc_if_i.cas_n),
        .we_n(sdc_if_i.we_n), .bank_select_lo(sdc_if_i.bank_select_lo),
        .bank_select_hi(sdc_if_i.bank_select_hi), .addr_bus(sdc_if_i.addr_bus),
        .byte_lane_mask(sdc_if_i.byte_lane_mask), .ctl_dq_oe_n(sdc_if_i.ctl_dq_oe_n),
        .mem_dq_oe_n(sdc_if_i.mem_dq_oe_n));
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        flt <= ~flt;
        if (refused_o === 1'b1) refusals <= refusals + 1;
    end
    // undriven lanes toggle so a stale value can never pass for read data
    always_comb begin
        for (int i = 0; i < MASK_W; i++) begin
            if (!sdc_if_i.mem_dq_oe_n[i]) sdc_if_i.data_io[8*i+:8] = sdc_if_i.mem_dq_out[8*i+:8];
            else if (!sdc_if_i.ctl_dq_oe_n) sdc_if_i.data_io[8*i+:8] = sdc_if_i.ctl_dq_out[8*i+:8];
            else sdc_if_i.data_io[8*i+:8] = {4{flt, ~flt}};
        end
    end
    task automatic give_verdict();
        $display("counts: %0d checked, %0d failures", checked, failures);
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic cmd(input sdc_op_t o, input logic [1:0] b, input logic [11:0] a,
        input logic [3:0] m, input logic [31:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        op <= o;
        bank <= b;
        addr <= a;
        mask <= m;
        wdata <= d;
    endtask : cmd
    task automatic gap(input int n);
        @(posedge clk_i);
        req <= 1'b0;
        repeat (n) @(posedge clk_i);
        #1;
    endtask : gap
    task automatic set_cke(input logic v);
        @(posedge clk_i);
        cke <= v;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : set_cke
    // returns in the cycle the device first drives a read beat
    task automatic rd_beat(input logic [1:0] b, input logic [11:0] a, input logic [3:0] m);
        cmd(SDC_OP_RD, b, a, m, 32'h0);
        gap(0);
        for (int i = 0; i < 10 && sdc_if_i.mem_dq_oe_n === 4'hF; i++) begin
            @(posedge clk_i);
            #1;
        end
    endtask : rd_beat
    task automatic t_mode();
        cmd(SDC_OP_MRS, 2'h1, 12'h020, 4'hF, 32'h0);
        gap(4);
        `CHK(mode_word, {2'h1, 12'h020})
        $display("test mode done");
    endtask : t_mode
    task automatic t_refresh();
        cmd(SDC_OP_REF, 2'h0, 12'h000, 4'hF, 32'h0);
        gap(4);
        `CHK(ref_cnt, 8'h01)
        cmd(SDC_OP_REF, 2'h0, 12'h000, 4'hF, 32'h0);
        cke <= 1'b0;
        gap(4);
        `CHK(sref, 1'b1)
        set_cke(1'b1);
        `CHK(sref, 1'b0)
        set_cke(1'b0);
        `CHK(pdown, 1'b1)
        `CHK(suspend, 1'b0)
        set_cke(1'b1);
        `CHK(pdown, 1'b0)
        $display("test refresh done");
    endtask : t_refresh
    task automatic t_rw();
        cmd(SDC_OP_ACT, 2'h1, 12'h123, 4'h0, 32'h0);
        gap(4);
        `CHK(mem_open, 4'h2)
        `CHK(ctl_open, 4'h2)
        cmd(SDC_OP_WR, 2'h1, 12'h005, 4'h0, 32'hA1B2C3D4);
        cmd(SDC_OP_WR, 2'h1, 12'h005, 4'h5, 32'h11223344);
        gap(4);
        rd_beat(2'h1, 12'h005, 4'h0);
        `CHK(sdc_if_i.mem_dq_oe_n, 4'h0)
        @(posedge clk_i);
        #1;
        `CHK(rdata_o, 32'h11B233D4)
        gap(4);
        rd_beat(2'h1, 12'h005, 4'h8);
        `CHK(sdc_if_i.mem_dq_oe_n, 4'h8)
        @(posedge clk_i);
        #1;
        `CHK(rdata_o[23:0], 24'hB233D4)
        gap(4);
        cmd(SDC_OP_ACT, 2'h1, 12'h456, 4'h0, 32'h0);
        cmd(SDC_OP_MRS, 2'h0, 12'h003, 4'h0, 32'h0);
        gap(4);
        `CHK(refusals, 2)
        `CHK(mode_word, {2'h1, 12'h020})
        `CHK(mem_open, 4'h2)
        $display("test read write done");
    endtask : t_rw
    task automatic t_pre();
        cmd(SDC_OP_ACT, 2'h3, 12'hABC, 4'h0, 32'h0);
        gap(4);
        `CHK(mem_open, 4'hA)
        cmd(SDC_OP_PRE, 2'h1, 12'h000, 4'h0, 32'h0);
        gap(4);
        `CHK(mem_open, 4'h8)
        cmd(SDC_OP_ACT, 2'h0, 12'h001, 4'h0, 32'h0);
        cmd(SDC_OP_PRE, 2'h2, 12'h400, 4'h0, 32'h0);
        gap(4);
        `CHK(mem_open, 4'h0)
        `CHK(ctl_open, 4'h0)
        $display("test precharge done");
    endtask : t_pre
    task automatic t_susp();
        cmd(SDC_OP_ACT, 2'h2, 12'h0F0, 4'h0, 32'h0);
        gap(4);
        set_cke(1'b0);
        `CHK(suspend, 1'b1)
        `CHK(pdown, 1'b0)
        set_cke(1'b1);
        `CHK(suspend, 1'b0)
        `CHK(mem_open, 4'h4)
        cmd(SDC_OP_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
        gap(4);
        `CHK(mem_open, 4'h0)
        $display("test suspend done");
    endtask : t_susp
    task automatic t_burst();
        int beats;
        beats = 0;
        cmd(SDC_OP_ACT, 2'h0, 12'h010, 4'h0, 32'h0);
        cmd(SDC_OP_WR, 2'h0, 12'h402, 4'h0, 32'h5A5A0F0F);
        gap(4);
        `CHK(mem_open, 4'h0)
        `CHK(ctl_open, 4'h0)
        cmd(SDC_OP_MRS, 2'h0, 12'h003, 4'hF, 32'h0);
        cmd(SDC_OP_ACT, 2'h0, 12'h010, 4'h0, 32'h0);
        cmd(SDC_OP_RD, 2'h0, 12'h002, 4'h0, 32'h0);
        cmd(SDC_OP_BST, 2'h0, 12'h000, 4'h0, 32'h0);
        gap(0);
        repeat (10) begin
            @(posedge clk_i);
            #1;
            if (sdc_if_i.mem_dq_oe_n !== 4'hF) beats++;
        end
        `CHK(beats, 1)
        cmd(SDC_OP_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
        gap(4);
        `CHK(mem_open, 4'h0)
        $display("test burst stop done");
    endtask : t_burst
    initial begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        req = 1'b0;
        op = SDC_OP_NOP;
        bank = '0;
        addr = '0;
        mask = 4'hF;
        wdata = '0;
        cke = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_mode();
        t_refresh();
        t_rw();
        t_pre();
        t_susp();
        t_burst();
        give_verdict();
    end
    // all tests finish in well under a thousand cycles
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
endmodule : sdram_command_decode_tb
